/* sfp_front_end.sv */
`timescale 1ns/1ps
module sfp_front_end (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] data_in_i,
  output logic [3:0] data_out_o,
  output logic [3:0] data_oe_o,
  input wire logic pin_clear_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import sfp_pkg::*;

  sfp_state_s s;
  sfp_state_s n;
  sfp_lanes_e mode;
  logic [3:0] wv;
  logic qe, ded, psel, dir;
  logic cs_fall, cs_rise, sclk_rise, sclk_fall;
  logic quad_xfer, refused, pause_fn, line3_clr, pause_req;
  logic wp_blk, clear_low, clr_hit, req, wr, rd;

  // ----------------------------------------------------------------
  // decoded configuration and edges
  // ----------------------------------------------------------------
  assign qe = s.ctrl[CB_QE];
  assign psel = s.ctrl[CB_SEL];
  assign ded = s.ctrl[CB_DED];
  assign dir = s.ctrl[CB_DIR];
  assign mode = sfp_lanes_e'(s.ctrl[CB_MODE +: 2]);
  assign wv = (mode == LN_QUAD) ? 4'h4 : (mode == LN_DUAL) ? 4'h2 : 4'h1;
  assign cs_fall = s.cs_d & ~s.cs_s2;
  assign cs_rise = ~s.cs_d & s.cs_s2;
  // modes 0 and 3
  // edge finding does not care about the idle level of the clock
  assign sclk_rise = s.sclk_s2 & ~s.sclk_d & ~s.paused & ~s.cs_s2;
  assign sclk_fall = ~s.sclk_s2 & s.sclk_d & ~s.paused & ~s.cs_s2;
  assign quad_xfer = (s.phase == PH_DATA) && (mode == LN_QUAD);
  // phase-free, so the first data cycle cannot drive either
  assign refused = (mode == LN_QUAD) & ~qe;
  assign pause_fn = ~qe & (ded | ~psel);
  assign line3_clr = ~qe & ~ded & psel;
  assign pause_req = pause_fn & ~quad_xfer & ~s.d_s2[3] & ~s.cs_s2;
  assign wp_blk = ~qe & ~s.d_s2[2] & (s.prot[1:0] == SRP_HW);
  assign clear_low = (ded & ~s.clr_s2) | (line3_clr & ~s.d_s2[3]);
  assign clr_hit = (s.clr_cnt == CLR_CYC);
  assign req = wb_cyc_i & wb_stb_i & ~s.ack;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign rd = req & ~wb_we_i;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    // pins are asynchronous to clk_i: two flops before use
    n.cs_s1 = cs_n_i;
    n.cs_s2 = s.cs_s1;
    n.cs_d = s.cs_s2;
    n.sclk_s1 = sclk_i;
    n.sclk_s2 = s.sclk_s1;
    n.sclk_d = s.sclk_s2;
    n.clr_s1 = pin_clear_n_i;
    n.clr_s2 = s.clr_s1;
    n.d_s1 = data_in_i;
    n.d_s2 = s.d_s1;

    // bus side; clears come first so hardware sets win
    n.ack = req;
    n.dat = 32'h0;
    if (rd) begin
      case (wb_adr_i)
        ADR_CTRL: n.dat = {26'h0, s.ctrl};
        ADR_PROT: n.dat = {24'h0, s.prot};
        ADR_STAT: n.dat = {24'h0, s.quad_ref, s.tx_taken,
                           (s.busy_cnt != 8'h0), s.wblk, s.rx_valid,
                           s.paused, ~s.cs_s2, s.armed};
        ADR_RXD: n.dat = {24'h0, s.rx_data};
        ADR_TXD: n.dat = {24'h0, s.tx_data};
        ADR_INSTR: n.dat = {24'h0, s.instr};
        default: n.dat = 32'h0;
      endcase
      if (wb_adr_i == ADR_RXD) begin
        n.rx_valid = 1'b0;
      end
    end
    if (wr) begin
      case (wb_adr_i)
        ADR_CTRL: n.ctrl = wb_dat_i[5:0];
        ADR_PROT: begin
          if (wp_blk) begin
            n.wblk = 1'b1;
          end else begin
            n.prot = wb_dat_i[7:0];
          end
        end
        ADR_STAT: begin
          if (wb_dat_i[ST_WBLK]) n.wblk = 1'b0;
          if (wb_dat_i[ST_TXT]) n.tx_taken = 1'b0;
          if (wb_dat_i[ST_QREF]) n.quad_ref = 1'b0;
        end
        ADR_TXD: n.tx_data = wb_dat_i[7:0];
        ADR_OP: begin
          if (s.busy_cnt == 8'h0) n.busy_cnt = OP_CYCLES;
        end
        default: n.ack = req;
      endcase
    end

    if (s.busy_cnt != 8'h0) begin
      n.busy_cnt = s.busy_cnt - 8'h1;
    end

    if (!clear_low) begin
      n.clr_cnt = 6'h0;
    end else if (!clr_hit) begin
      n.clr_cnt = s.clr_cnt + 6'h1;
    end

    if (cs_fall) begin
      n.armed = 1'b1;
    end

    // frame state is kept, so release just resumes
    if (s.cs_s2) begin
      n.paused = 1'b0;
    end else if (!s.sclk_s2) begin
      n.paused = pause_req;
    end

    // frame engine
    if (clr_hit) begin
      n.armed = 1'b0;
      n.busy_cnt = 8'h0;
      n.paused = 1'b0;
      n.phase = PH_IDLE;
      n.cnt = 4'h0;
    end else if (s.cs_s2 || cs_rise) begin
      n.phase = PH_IDLE;
      n.cnt = 4'h0;
    end else if (cs_fall) begin
      n.phase = PH_INSTR;
      n.cnt = 4'h0;
    end else begin
      case (s.phase)
        PH_INSTR: begin
          if (sclk_rise) begin
            n.sh_in = {s.sh_in[6:0], s.d_s2[0]};
            n.cnt = s.cnt + 4'h1;
            if (s.cnt == 4'h7) begin
              n.instr = {s.sh_in[6:0], s.d_s2[0]};
              n.phase = PH_DATA;
              n.cnt = 4'h0;
              n.tx_sh = s.tx_data;
              if (mode == LN_QUAD && !qe) n.quad_ref = 1'b1;
            end
          end
        end
        PH_DATA: begin
          if (refused) begin
            n.cnt = s.cnt;
          end else if (!dir && sclk_rise) begin
            case (mode)
              LN_QUAD: n.sh_in = {s.sh_in[3:0], s.d_s2};
              LN_DUAL: n.sh_in = {s.sh_in[5:0], s.d_s2[1:0]};
              default: n.sh_in = {s.sh_in[6:0], s.d_s2[0]};
            endcase
            n.cnt = s.cnt + wv;
            if (s.cnt + wv == 4'h8) begin
              n.rx_data = n.sh_in;
              n.rx_valid = 1'b1;
              n.cnt = 4'h0;
            end
          end else if (dir && sclk_fall) begin
            case (mode)
              LN_QUAD: n.dout = s.tx_sh[7:4];
              LN_DUAL: n.dout = {2'b00, s.tx_sh[7:6]};
              default: n.dout = {2'b00, s.tx_sh[7], 1'b0};
            endcase
            n.tx_sh = s.tx_sh << wv;
            n.cnt = s.cnt + wv;
            if (s.cnt + wv == 4'h8) begin
              // byte repeats until software refreshes it
              n.tx_sh = s.tx_data;
              n.tx_taken = 1'b1;
              n.cnt = 4'h0;
            end
          end
        end
        default: n.cnt = 4'h0;
      endcase
    end

    n.oe = 4'h0;
    if (!s.cs_s2 && !n.paused && n.phase == PH_DATA && dir && !refused
        && !clr_hit) begin
      case (mode)
        LN_QUAD: n.oe = 4'hf;
        LN_DUAL: n.oe = 4'h3;
        default: n.oe = 4'h2;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '{cs_s1: 1'b1, cs_s2: 1'b1, cs_d: 1'b1,
             sclk_s1: 1'b0, sclk_s2: 1'b0, sclk_d: 1'b0,
             clr_s1: 1'b1, clr_s2: 1'b1, d_s1: 4'hf, d_s2: 4'hf,
             armed: 1'b0, paused: 1'b0, phase: PH_IDLE, cnt: 4'h0,
             sh_in: DATA_RST, instr: DATA_RST, tx_sh: DATA_RST,
             rx_data: DATA_RST, tx_data: DATA_RST, prot: PROT_RST,
             ctrl: CTRL_RST, rx_valid: 1'b0, wblk: 1'b0,
             tx_taken: 1'b0, quad_ref: 1'b0, busy_cnt: 8'h0,
             clr_cnt: 6'h0, dout: 4'h0, oe: 4'h0, ack: 1'b0,
             dat: 32'h0};
    end else begin
      s <= n;
    end
  end

  assign data_out_o = s.dout;
  assign data_oe_o = s.oe;
  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.dat;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_DESEL_RELEASE: assert property (
    cs_n_i [*3] |=> data_oe_o == 4'h0)
    else $error("data lines driven while deselected");
  AST_ARM_ON_FALL: assert property (
    $rose(s.armed) |-> $past(s.cs_d) && !$past(s.cs_s2))
    else $error("armed without select falling edge");
  AST_SAMPLE_ON_RISE: assert property (
    $changed(s.sh_in) |-> $past(sclk_rise))
    else $error("input shifted without clock rise");
  AST_DRIVE_ON_FALL: assert property (
    $changed(s.dout) |-> $past(sclk_fall) && $past(s.ctrl[CB_DIR]))
    else $error("output changed without clock fall");
  AST_QUAD_NEEDS_QE: assert property (
    s.oe[2] |-> s.ctrl[CB_QE] && s.ctrl[CB_MODE +: 2] == LN_QUAD)
    else $error("line 2 driven without quad enable");
  AST_WP_BLOCKS: assert property (
    wr && wb_adr_i == ADR_PROT && wp_blk |=> $stable(s.prot) && s.wblk)
    else $error("protect write not blocked");
  AST_PAUSE_FREEZE: assert property (
    s.paused && $past(s.paused) |-> $stable(s.cnt) && s.oe == 4'h0)
    else $error("frame moved during pause");
  AST_PAUSE_CLK_LOW: assert property (
    $changed(s.paused) && !s.cs_s2 |-> !$past(s.sclk_s2))
    else $error("pause changed while clock high");
  AST_CLEAR_ABORT: assert property (
    clr_hit |=> !s.armed && s.busy_cnt == 8'h0 && s.phase == PH_IDLE)
    else $error("clear pulse did not restore state");
  AST_CS_RISE_IDLE: assert property (
    cs_rise |=> s.phase == PH_IDLE && s.cnt == 4'h0)
    else $error("frame survived select rise");
  AST_BUSY_RUNS: assert property (
    s.busy_cnt != 8'h0 && !clr_hit
      |=> s.busy_cnt == $past(s.busy_cnt) - 8'h1)
    else $error("internal cycle stalled");

  COV_RX_BYTE: cover property ($rose(s.rx_valid));
  COV_TX_BYTE: cover property ($rose(s.tx_taken));
  COV_PAUSE: cover property ($rose(s.paused) ##[1:200] $fell(s.paused));
  COV_CLEAR: cover property (clr_hit);

endmodule : sfp_front_end

/* sfp_pkg.sv */
package sfp_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_PROT = 8'h04;
  localparam logic [7:0] ADR_STAT = 8'h08;
  localparam logic [7:0] ADR_RXD = 8'h0c;
  localparam logic [7:0] ADR_TXD = 8'h10;
  localparam logic [7:0] ADR_OP = 8'h14;
  localparam logic [7:0] ADR_INSTR = 8'h18;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CB_QE = 0;
  localparam int CB_SEL = 1;
  localparam int CB_DED = 2;
  localparam int CB_MODE = 3;
  localparam int CB_DIR = 5;
  localparam int ST_ARMED = 0;
  localparam int ST_SELECTED = 1;
  localparam int ST_PAUSED = 2;
  localparam int ST_RXV = 3;
  localparam int ST_WBLK = 4;
  localparam int ST_BUSY = 5;
  localparam int ST_TXT = 6;
  localparam int ST_QREF = 7;
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [7:0] PROT_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [1:0] SRP_HW = 2'h1;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int CLR_TIME_NS = 1000;
  localparam logic [5:0] CLR_CYC =
    6'((CLR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] OP_CYCLES = 8'hc8;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_INSTR = 2'b01,
    PH_DATA = 2'b10
  } sfp_phase_e;

  typedef enum logic [1:0] {
    LN_SINGLE = 2'b00,
    LN_DUAL = 2'b01,
    LN_QUAD = 2'b10
  } sfp_lanes_e;

  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic cs_d;
    logic sclk_s1;
    logic sclk_s2;
    logic sclk_d;
    logic clr_s1;
    logic clr_s2;
    logic [3:0] d_s1;
    logic [3:0] d_s2;
    logic armed;
    logic paused;
    sfp_phase_e phase;
    logic [3:0] cnt;
    logic [7:0] sh_in;
    logic [7:0] instr;
    logic [7:0] tx_sh;
    logic [7:0] rx_data;
    logic [7:0] tx_data;
    logic [7:0] prot;
    logic [5:0] ctrl;
    logic rx_valid;
    logic wblk;
    logic tx_taken;
    logic quad_ref;
    logic [7:0] busy_cnt;
    logic [5:0] clr_cnt;
    logic [3:0] dout;
    logic [3:0] oe;
    logic ack;
    logic [31:0] dat;
  } sfp_state_s;

endpackage : sfp_pkg

/* sfp_spi_master.sv */
`timescale 1ns/1ps
// ----------------------------------------
// far-side spi master, half period 4 clocks
// ----------------------------------------
module sfp_spi_master (
  input wire logic clk_i,
  input wire logic [3:0] dout_i,
  input wire logic [3:0] doe_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic [3:0] line_o
);
  logic [3:0] drv = 4'hc;
  logic [3:0] en = 4'hc;
  logic flip = 1'b0;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
  end
  // released lines wander so stale levels never pass
  always @(posedge clk_i) flip <= ~flip;
  assign line_o = (doe_i & dout_i) | (~doe_i & en & drv)
    | (~doe_i & ~en & {4{flip}});

  task automatic half();
    repeat (4) @(posedge clk_i);
  endtask : half

  task automatic pin(input int k, input logic v);
    drv[k] <= v;
    en[k] <= 1'b1;
  endtask : pin

  task automatic frame(input logic m3, input int w, input logic rd,
    input int n, input int hold, input logic [15:0] tx,
    output logic [7:0] rx);
    logic [15:0] sh;
    logic [3:0] mc;
    int wc;
    sh = tx;
    rx = 8'h00;
    @(posedge clk_i);
    sclk_o <= m3;
    half();
    cs_n_o <= 1'b0;
    half();
    for (int c = 0; c < n; c++) begin
      wc = (c < 8) ? 1 : w;
      mc = (wc == 4) ? 4'hf : ((wc == 2) ? 4'h3 : 4'h1);
      sclk_o <= 1'b0;
      if (rd && c >= 8) begin
        en <= en & ~mc;
      end else begin
        en <= en | mc;
        drv <= (drv & ~mc) | ((sh[15:12] >> (4 - wc)) & mc);
        sh = sh << wc;
      end
      half();
      sclk_o <= 1'b1;
      half();
      if (c >= 8) begin
        rx = 8'((rx << w)
          | ((w == 1) ? {3'h0, line_o[1]} : line_o & mc));
      end
      if (c == hold) begin
        sclk_o <= 1'b0;
        half();
        drv[3] <= 1'b0;
        repeat (2) begin
          half();
          sclk_o <= 1'b1;
          drv[0] <= ~drv[0];
          half();
          sclk_o <= 1'b0;
        end
        drv[3] <= 1'b1;
        half();
      end
    end
    if (!m3) sclk_o <= 1'b0;
    half();
    cs_n_o <= 1'b1;
    en <= 4'hc;
    drv <= 4'hc;
    half();
  endtask : frame
endmodule : sfp_spi_master

/* sfp_front_end_tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) chk(32'(g), 32'(e))
module sfp_front_end_tb;
  import sfp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sclk;
  logic cs_n;
  logic clr_n = 1'b1;
  logic [3:0] line;
  logic [3:0] dout;
  logic [3:0] doe;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [7:0] rx;
  int mismatches = 0;
  int num_checks = 0;
  logic [7:0] cv [5] = '{8'h20, 8'h28, 8'h31, 8'h08, 8'h11};
  logic [7:0] dv [5] = '{8'h96, 8'h3c, 8'h7e, 8'h5a, 8'hc3};
  int wv [5] = '{1, 2, 4, 2, 4};

  always #12.5 clk_i = ~clk_i;

  sfp_front_end sfp_front_end_i (.clk_i(clk_i), .rst_i(rst_i),
    .sclk_i(sclk), .cs_n_i(cs_n), .data_in_i(line), .data_out_o(dout),
    .data_oe_o(doe), .pin_clear_n_i(clr_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
  sfp_spi_master sfp_spi_master_i (.clk_i(clk_i), .dout_i(dout),
    .doe_i(doe), .sclk_o(sclk), .cs_n_o(cs_n), .line_o(line));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic wb(input logic w, input logic [7:0] a,
    input logic [7:0] d, output logic [31:0] q);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    wb(1'b0, a, 8'h00, q);
    `CHK(q, {24'h0, e});
  endtask : chk_rd

  task automatic pin(input int k, input logic v);
    sfp_spi_master_i.pin(k, v);
    repeat (4) @(posedge clk_i);
  endtask : pin

  // held past clear threshold plus sync delay
  task automatic clr_pulse(input logic ded);
    if (ded) clr_n <= 1'b0;
    else pin(3, 1'b0);
    repeat (48) @(posedge clk_i);
    if (ded) clr_n <= 1'b1;
    else pin(3, 1'b1);
    repeat (4) @(posedge clk_i);
  endtask : clr_pulse

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    #400000;
    mismatches++;
    close_out();
  end

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    chk_rd(ADR_CTRL, CTRL_RST);
    chk_rd(ADR_PROT, PROT_RST);
    chk_rd(ADR_STAT, 8'h00);
    chk_rd(8'h1c, 8'h00);
    $display("done reset");
    sfp_spi_master_i.frame(1'b0, 1, 1'b0, 8, -1, 16'ha500, rx);
    chk_rd(ADR_INSTR, 8'ha5);
    chk_rd(ADR_STAT, 8'h01);
    sfp_spi_master_i.frame(1'b0, 1, 1'b0, 12, -1, 16'h3cf0, rx);
    sfp_spi_master_i.frame(1'b0, 1, 1'b0, 4, -1, 16'h6600, rx);
    chk_rd(ADR_INSTR, 8'h3c);
    chk_rd(ADR_STAT, 8'h01);
    $display("done framing");
    sfp_spi_master_i.frame(1'b1, 1, 1'b0, 16, -1, 16'h0281, rx);
    chk_rd(ADR_RXD, 8'h81);
    sfp_spi_master_i.frame(1'b0, 1, 1'b0, 16, 11, 16'h025a, rx);
    chk_rd(ADR_RXD, 8'h5a);
    $display("done mode and pause");
    wr(ADR_CTRL, 8'h30);
    sfp_spi_master_i.frame(1'b0, 4, 1'b0, 10, -1, 16'h6bc3, rx);
    chk_rd(ADR_STAT, 8'h81);
    wr(ADR_STAT, 8'h80);
    foreach (cv[i]) begin
      wr(ADR_CTRL, cv[i]);
      wr(ADR_TXD, dv[i]);
      sfp_spi_master_i.frame(1'b0, wv[i], cv[i][5], 8 + 8 / wv[i], -1,
        {8'h0b, dv[i]}, rx);
      if (cv[i][5]) `CHK(rx, dv[i]);
      else chk_rd(ADR_RXD, dv[i]);
    end
    repeat (8) @(posedge clk_i);
    `CHK(doe, 4'h0);
    $display("done lanes");
    wr(ADR_STAT, 8'hd0);
    wr(ADR_CTRL, 8'h00);
    wr(ADR_PROT, 8'h01);
    pin(2, 1'b0);
    wr(ADR_PROT, 8'h1d);
    chk_rd(ADR_PROT, 8'h01);
    chk_rd(ADR_STAT, 8'h11);
    wr(ADR_CTRL, 8'h01);
    wr(ADR_PROT, 8'h1d);
    chk_rd(ADR_PROT, 8'h1d);
    pin(2, 1'b1);
    wr(ADR_STAT, 8'h10);
    $display("done protect");
    wr(ADR_OP, 8'h01);
    sfp_spi_master_i.frame(1'b0, 1, 1'b0, 8, -1, 16'h0500, rx);
    chk_rd(ADR_STAT, 8'h21);
    wr(ADR_CTRL, 8'h07);
    clr_pulse(1'b1);
    chk_rd(ADR_STAT, 8'h00);
    chk_rd(ADR_CTRL, 8'h07);
    $display("done dedicated clear");
    sfp_spi_master_i.frame(1'b0, 1, 1'b0, 8, -1, 16'h0500, rx);
    wr(ADR_CTRL, 8'h03);
    clr_pulse(1'b0);
    chk_rd(ADR_STAT, 8'h01);
    wr(ADR_CTRL, 8'h02);
    clr_pulse(1'b0);
    chk_rd(ADR_STAT, 8'h00);
    $display("done shared clear");
    close_out();
  end
endmodule : sfp_front_end_tb
